// *** mcu_interrupt_enable_flag_bank.sv ***
// Implementation choices: the AHB-Lite slave port and the register offsets.
`include "irq_bank_consts.svh"
module mcu_interrupt_enable_flag_bank (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // event sources, one-cycle pulses or levels
  input wire irq_bank_pkg::core_evt_t core_evt,
  input wire irq_bank_pkg::req_one_evt_t req_one_evt,
  input wire irq_bank_pkg::req_two_evt_t req_two_evt,
  input wire logic ext_pin,
  input wire logic [7:0] pin_change_individual_flags,
  input wire logic [7:0] pir3_flags,
  input wire logic [7:0] pir4_flags,
  // core handshake
  input wire logic irq_accept,
  output logic core_irq_request,
  output logic [7:0] vector_addr,
  // block interrupt
  output logic irq
);
  logic [7:0] core_interrupt_control;
  logic [7:0] peripheral_enable_one;
  logic [7:0] peripheral_enable_two;
  logic [7:0] peripheral_enable_three;
  logic [7:0] peripheral_enable_four;
  logic [7:0] peripheral_request_one;
  logic [7:0] peripheral_request_two;
  logic ext_pin_edge_select;
  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic ext_pin_d;
  logic ph_write;
  logic ph_read;
  logic [11:0] ph_addr;
  logic [7:0] wbyte;
  logic ext_edge;
  logic pc_summary;
  logic core_pend;
  logic periph_pend;
  logic [7:0] next_req_one;
  logic [7:0] next_req_two;
  logic [7:0] read_byte;

  // decode of an offset, used by write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wbyte = hwdata[7:0];
  assign vector_addr = 8'h04;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write <= 1'b0;
      ph_read <= 1'b0;
      ph_addr <= 12'h000;
    end else if (hready) begin
      ph_write <= hsel && htrans[1] && hwrite;
      ph_read <= hsel && htrans[1] && !hwrite;
      ph_addr <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_pin_d <= 1'b0;
    end else begin
      ext_pin_d <= ext_pin;
    end
  end
  assign ext_edge = ext_pin_edge_select ? (ext_pin && !ext_pin_d)
                                        : (!ext_pin && ext_pin_d);

  assign pc_summary = |pin_change_individual_flags;

  // core control register; set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_interrupt_control <= `RESET_BYTE;
    end else begin
      if (ph_write && hit(ph_addr, `OFS_CORE_CTRL)) begin
        core_interrupt_control[7:1] <= wbyte[7:1];
      end
      if (irq_accept && core_interrupt_control[`BIT_GIE]) begin
        core_interrupt_control[`BIT_GIE] <= 1'b0;
      end
      if (core_evt.timer0_ovf) begin
        core_interrupt_control[`BIT_T0IF] <= 1'b1;
      end
      if (core_evt.ext_pin || ext_edge) begin
        core_interrupt_control[`BIT_EXTIF] <= 1'b1;
      end
      core_interrupt_control[`BIT_PCIF] <= pc_summary;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_enable_one <= `RESET_BYTE;
      peripheral_enable_two <= `RESET_BYTE;
      peripheral_enable_three <= `RESET_BYTE;
      peripheral_enable_four <= `RESET_BYTE;
      ext_pin_edge_select <= 1'b0;
      evt_mask <= 2'b00;
    end else if (ph_write) begin
      if (hit(ph_addr, `OFS_PEN_ONE)) begin
        peripheral_enable_one <= wbyte & `MASK_PEN_ONE;
      end
      if (hit(ph_addr, `OFS_PEN_TWO)) begin
        peripheral_enable_two <= wbyte & `MASK_PEN_TWO;
      end
      if (hit(ph_addr, `OFS_PEN_THREE)) begin
        peripheral_enable_three <= wbyte & `MASK_PEN_THREE;
      end
      if (hit(ph_addr, `OFS_PEN_FOUR)) begin
        peripheral_enable_four <= wbyte & `MASK_PEN_FOUR;
      end
      if (hit(ph_addr, `OFS_EDGE_SEL)) begin
        ext_pin_edge_select <= wbyte[0];
      end
      if (hit(ph_addr, `OFS_EVT_MASK)) begin
        evt_mask <= wbyte[1:0];
      end
    end
  end

  // next value of request flags: write, then hardware set
  always_comb begin
    next_req_one = peripheral_request_one;
    next_req_two = peripheral_request_two;
    if (ph_write && hit(ph_addr, `OFS_PREQ_ONE)) begin
      next_req_one = wbyte & `MASK_PREQ_ONE;
    end
    if (ph_write && hit(ph_addr, `OFS_PREQ_TWO)) begin
      next_req_two = wbyte & `MASK_PREQ_TWO;
    end
    next_req_one = next_req_one | {req_one_evt.timer1_gate,
      req_one_evt.adc_done, 3'b000, req_one_evt.capcmp_one,
      req_one_evt.timer2_match, req_one_evt.timer1_ovf};
    // second capture flag at bit 0
    next_req_two = next_req_two | {1'b0, req_two_evt.comparator_two,
      req_two_evt.comparator_one, 2'b00, req_two_evt.timer6_match,
      req_two_evt.timer4_match, req_two_evt.capcmp_two};
  end

  // request flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_request_one <= `RESET_BYTE;
      peripheral_request_two <= `RESET_BYTE;
    end else begin
      peripheral_request_one <= next_req_one;
      peripheral_request_two <= next_req_two;
    end
  end

  assign core_pend =
    (core_interrupt_control[`BIT_T0IE] & core_interrupt_control[`BIT_T0IF]) |
    (core_interrupt_control[`BIT_EXTIE] &
     core_interrupt_control[`BIT_EXTIF]) |
    (core_interrupt_control[`BIT_PCIE] & core_interrupt_control[`BIT_PCIF]);

  assign periph_pend = |(peripheral_enable_one & peripheral_request_one) |
    |(peripheral_enable_two & peripheral_request_two) |
    |(peripheral_enable_three & pir3_flags) |
    |(peripheral_enable_four & pir4_flags);

  assign core_irq_request = core_interrupt_control[`BIT_GIE] &
    (core_pend | (core_interrupt_control[`BIT_PERIPH_GROUP_ENABLE] & periph_pend));

  // read mux; unimplemented bits read zero
  always_comb begin
    read_byte = 8'h00;
    if (hit(ph_addr, `OFS_CORE_CTRL)) read_byte = core_interrupt_control;
    if (hit(ph_addr, `OFS_PEN_ONE)) read_byte = peripheral_enable_one;
    if (hit(ph_addr, `OFS_PEN_TWO)) read_byte = peripheral_enable_two;
    if (hit(ph_addr, `OFS_PEN_THREE)) read_byte = peripheral_enable_three;
    if (hit(ph_addr, `OFS_PEN_FOUR)) read_byte = peripheral_enable_four;
    if (hit(ph_addr, `OFS_PREQ_ONE)) read_byte = peripheral_request_one;
    if (hit(ph_addr, `OFS_PREQ_TWO)) read_byte = peripheral_request_two;
    if (hit(ph_addr, `OFS_EDGE_SEL)) read_byte = {7'h00, ext_pin_edge_select};
    if (hit(ph_addr, `OFS_EVT_STATUS)) read_byte = {6'h00, evt_status};
    if (hit(ph_addr, `OFS_EVT_MASK)) read_byte = {6'h00, evt_mask};
  end
  assign hrdata = {24'h000000, read_byte};

  // sticky status: bit0 core request rose, bit1 any accept; read clears
  logic req_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_status <= 2'b00;
      req_d <= 1'b0;
    end else begin
      req_d <= core_irq_request;
      if (ph_read && hit(ph_addr, `OFS_EVT_STATUS)) begin
        evt_status <= 2'b00;
      end
      // set beats the read clear
      if (core_irq_request && !req_d) evt_status[0] <= 1'b1;
      if (irq_accept) evt_status[1] <= 1'b1;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end
endmodule : mcu_interrupt_enable_flag_bank

// *** irq_bank_consts.svh ***
`ifndef IRQ_BANK_CONSTS_SVH
`define IRQ_BANK_CONSTS_SVH
`define OFS_CORE_CTRL 12'h000
`define OFS_PEN_ONE 12'h004
`define OFS_PEN_TWO 12'h008
`define OFS_PEN_THREE 12'h00c
`define OFS_PEN_FOUR 12'h010
`define OFS_PREQ_ONE 12'h014
`define OFS_PREQ_TWO 12'h018
`define OFS_EDGE_SEL 12'h01c
`define OFS_EVT_STATUS 12'h020
`define OFS_EVT_MASK 12'h024
`define MASK_CORE_W 8'hfe
`define MASK_PEN_ONE 8'hc7
`define MASK_PEN_TWO 8'h67
`define MASK_PEN_THREE 8'h30
`define MASK_PEN_FOUR 8'hff
`define MASK_PREQ_ONE 8'hc7
`define MASK_PREQ_TWO 8'h67
`define BIT_GIE 7
`define BIT_PERIPH_GROUP_ENABLE 6
`define BIT_T0IE 5
`define BIT_EXTIE 4
`define BIT_PCIE 3
`define BIT_T0IF 2
`define BIT_EXTIF 1
`define BIT_PCIF 0
`define RESET_BYTE 8'h00
`endif

// *** irq_bank_pkg.sv ***
package irq_bank_pkg;
  // one entry per source in the request-one and request-two registers
  typedef struct packed {
    logic timer1_gate;
    logic adc_done;
    logic capcmp_one;
    logic timer2_match;
    logic timer1_ovf;
  } req_one_evt_t;
  typedef struct packed {
    logic comparator_two;
    logic comparator_one;
    logic timer6_match;
    logic timer4_match;
    logic capcmp_two;
  } req_two_evt_t;
  typedef struct packed {
    logic timer0_ovf;
    logic ext_pin;
  } core_evt_t;
endpackage : irq_bank_pkg

// *** cpu_core_model.sv ***
module cpu_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request in, acceptance out
  input wire logic req,
  input wire logic take,
  input wire logic [3:0] lag,
  output logic accept
);
  logic [3:0] cnt;
  // only a raised request
  // lag+1 cycles of steady request, then one accept pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      accept <= 1'b0;
    end else if (take && req && !accept) begin
      cnt <= (cnt == lag) ? 4'h0 : cnt + 4'h1;
      accept <= (cnt == lag);
    end else begin
      cnt <= 4'h0;
      accept <= 1'b0;
    end
  end
endmodule : cpu_core_model

// *** irq_bank_monitor.sv ***
module irq_bank_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // events and core side
  input wire irq_bank_pkg::core_evt_t core_evt,
  input wire irq_bank_pkg::req_one_evt_t req_one_evt,
  input wire logic [7:0] pin_change_individual_flags,
  input wire logic irq_accept,
  input wire logic core_irq_request,
  input wire logic [7:0] vector_addr
);
  logic rd;
  logic [11:0] ad;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read data phase, one cycle behind the taken address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd <= 1'b0;
      ad <= 12'h000;
    end else begin
      rd <= hsel && hready && htrans[1] && !hwrite;
      ad <= haddr[11:0];
    end
  end
  sequence core_rd_s;
    rd && ad == 12'h000;
  endsequence
  upper_zero_a:
    assert property (rd |-> hrdata[31:8] == 24'h0) else $error("upper bits");
  unmapped_zero_a:
    assert property (rd && ad >= 12'h028 |-> hrdata == 32'h0)
    else $error("unmapped read");
  third_mask_a:
    assert property (rd && ad == 12'h00c |-> (hrdata[7:0] & 8'hcf) == 8'h00)
    else $error("third enable bits");
  two_mask_a:
    assert property (rd && ad[3:0] == 4'h8 |-> (hrdata[7:0] & 8'h98) == 8'h00)
    else $error("second register bits");
  summary_track_a:
    assert property (core_rd_s |-> hrdata[0] == $past(|pin_change_individual_flags))
    else $error("summary flag");
  timer0_sticky_a:
    assert property (core_evt.timer0_ovf ##1 core_rd_s |-> hrdata[2])
    else $error("timer0 flag");
  ext_flag_a:
    assert property (core_evt.ext_pin ##1 core_rd_s |-> hrdata[1])
    else $error("pin flag");
  t1_flag_a:
    assert property (req_one_evt.timer1_ovf ##1 (rd && ad == 12'h014) |-> hrdata[0])
    else $error("timer1 flag");
  accept_drop_a:
    assert property (irq_accept |=> !core_irq_request) else $error("no drop");
  vector_fix_a:
    assert property (vector_addr == 8'h04) else $error("vector");
endmodule : irq_bank_monitor
bind mcu_interrupt_enable_flag_bank irq_bank_monitor u_mon (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .core_evt(core_evt),
  .req_one_evt(req_one_evt),
  .pin_change_individual_flags(pin_change_individual_flags),
  .irq_accept(irq_accept), .core_irq_request(core_irq_request),
  .vector_addr(vector_addr));

// *** tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hwrite, hreadyout, hresp, acc, take, req, irq, pin;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] pcf, pir3, vec;
  irq_bank_pkg::core_evt_t cev;
  irq_bank_pkg::req_one_evt_t rev;
  int err_count, checked, cyc;
  mcu_interrupt_enable_flag_bank u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_evt(cev), .req_one_evt(rev),
    .req_two_evt(5'h00), .ext_pin(pin), .pin_change_individual_flags(pcf),
    .pir3_flags(pir3), .pir4_flags(8'h00), .irq_accept(acc),
    .core_irq_request(req), .vector_addr(vec), .irq(irq));
  cpu_core_model u_core (.hclk(hclk), .hresetn(hresetn), .req(req),
    .take(take), .lag(4'h3), .accept(acc));
  task automatic end_sim;
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // one single transfer; waits on hready in both phases
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(r, {24'h0, e});
    chk({31'h0, hresp}, 32'h0);
  endtask : rd
  // request and irq looked at well after the last edge
  task automatic see(input logic [1:0] e);
    repeat (2) @(negedge hclk);
    chk({30'h0, req, irq}, {30'h0, e});
  endtask : see
  // event pulse lands during the read's address phase
  task automatic ev_rd(input logic [11:0] a, input logic [1:0] c,
                       input logic [4:0] q, input logic [7:0] e);
    fork
      bus(a, 1'b0, 8'h00);
      begin
        @(posedge hclk) cev <= c;
        rev <= q;
        @(posedge hclk) cev <= 2'b00;
        rev <= 5'h00;
      end
    join
    chk(r, {24'h0, e});
  endtask : ev_rd
  task automatic regs_t;
    logic [7:0] m [7] = '{8'hfe, 8'hc7, 8'h67, 8'h30, 8'hff, 8'hc7, 8'h67};
    for (int i = 0; i < 7; i++) begin
      rd(12'(4 * i), 8'h00);
      bus(12'(4 * i), 1'b1, 8'hff);
      rd(12'(4 * i), m[i]);
      bus(12'(4 * i), 1'b1, 8'h00);
    end
    rd(12'h028, 8'h00);
  endtask : regs_t
  task automatic gate_t;
    ev_rd(12'h014, 2'b00, 5'h01, 8'h01);
    bus(12'h004, 1'b1, 8'h01);
    bus(12'h000, 1'b1, 8'h40);
    see(2'b00);
    bus(12'h000, 1'b1, 8'h80);
    see(2'b00);
    bus(12'h000, 1'b1, 8'hc0);
    see(2'b10);
    bus(12'h004, 1'b1, 8'h00);
    see(2'b00);
    bus(12'h00c, 1'b1, 8'h10);
    @(posedge hclk) pir3 <= 8'h10;
    see(2'b10);
    bus(12'h00c, 1'b1, 8'h20);
    see(2'b00);
    bus(12'h004, 1'b1, 8'h01);
  endtask : gate_t
  task automatic irq_t;
    bus(12'h020, 1'b0, 8'h00);
    bus(12'h024, 1'b1, 8'h02);
    @(posedge hclk) take <= 1'b1;
    repeat (20) if (req === 1'b1) @(negedge hclk);
    see(2'b01);
    chk({24'h0, vec}, 32'h4);
    rd(12'h000, 8'h40);
    bus(12'h024, 1'b1, 8'h00);
    see(2'b00);
    bus(12'h024, 1'b1, 8'h02);
    see(2'b01);
    rd(12'h020, 8'h02);
    see(2'b00);
  endtask : irq_t
  task automatic pin_t;
    @(posedge hclk) pcf <= 8'h80;
    ev_rd(12'h000, 2'b11, 5'h00, 8'h47);
    bus(12'h000, 1'b1, 8'h00);
    rd(12'h000, 8'h01);
    @(posedge hclk) pcf <= 8'h00;
    rd(12'h000, 8'h00);
    // rising edge selected, pin rises then falls
    bus(12'h01c, 1'b1, 8'h01);
    @(posedge hclk) pin <= 1'b1;
    rd(12'h000, 8'h02);
    // clear stale flag before enabling the source
    bus(12'h000, 1'b1, 8'h00);
    @(posedge hclk) pin <= 1'b0;
    rd(12'h000, 8'h00);
    bus(12'h000, 1'b1, 8'h10);
    rd(12'h000, 8'h10);
  endtask : pin_t
  // free-running clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, pcf, pir3, take, cev, rev} = '0;
    pin = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    regs_t();
    gate_t();
    irq_t();
    pin_t();
    end_sim();
  end
endmodule : tb
